//--- watchdog_pkg.sv
// Behaviour
// - Code 000 disables; 001-011 give 2^6,2^8,2^10.
// - Codes 100-111 give 2^12,2^14,2^15,2^16.
// - Nonzero rate write enables and restarts period.
// - Unserviced period end requests system reset.
// - Special modes write anytime; normal modes once.
// - Zero rate write ignored, still consumes once.
// - Zero window write ignored, still consumes once.
// - Debug-stop free in special, else set-only.
// - Accepted nonzero rate with mask clear restarts.
// - Debug-stop rising zero to one restarts period.
// - Window mode: early service write resets part.
// - Repeated first keys fine; second key restarts.
// - Debug-stop set halts counters during debug.
// - Mask reads zero; set mask protects fields but debug-stop.
// - Masked write keeps the write-once allowance.
// - Halt-in-wait reinitialises and stops counter.
// - Run-in-stop clear freezes counter without reinit.
// - Special debug without stop uses longest, no window.
// - Control layout fixed, readable, bits 6..3 reset zero.
// - Service needs first then second key in period.
// - Enabled: any other service value resets part.
// - Service reads zero; ignored while rate is zero.
// - After reset load rate, window from inverted options.
package watchdog_pkg;

  // ----------------------------------------------------------------
  // Register map (index, byte address is four times it)
  // ----------------------------------------------------------------
  localparam logic [7:0] CONTROL_INDEX = 8'h3e;
  localparam logic [7:0] SERVICE_INDEX = 8'h3f;
  localparam int         ADDR_WIDTH    = 10;

  // ----------------------------------------------------------------
  // Control field positions
  // ----------------------------------------------------------------
  localparam int WINDOW_BIT    = 7;
  localparam int DEBUG_BIT     = 6;
  localparam int MASK_BIT      = 5;
  localparam int WAIT_BIT      = 4;
  localparam int STOP_BIT      = 3;
  localparam int RATE_MSB      = 2;
  localparam int OPT_WINDOW    = 3;

  // ----------------------------------------------------------------
  // Reset values and keys
  // ----------------------------------------------------------------
  localparam logic [2:0] RATE_OFF      = 3'h0;
  localparam logic [2:0] RATE_LONGEST  = 3'h7;
  localparam logic       FIELD_RESET   = 1'b0;
  localparam logic [7:0] KEY_FIRST     = 8'h55;
  localparam logic [7:0] KEY_SECOND    = 8'haa;

  // ----------------------------------------------------------------
  // Timeout exponents per rate code
  // ----------------------------------------------------------------
  localparam logic [4:0] EXP_R1 = 5'h06;
  localparam logic [4:0] EXP_R2 = 5'h08;
  localparam logic [4:0] EXP_R3 = 5'h0a;
  localparam logic [4:0] EXP_R4 = 5'h0c;
  localparam logic [4:0] EXP_R5 = 5'h0e;
  localparam logic [4:0] EXP_R6 = 5'h0f;
  localparam logic [4:0] EXP_R7 = 5'h10;

endpackage

//--- windowed_watchdog_control.sv
`timescale 1ns/10ps
module windowed_watchdog_control (
  // Clock and reset
  input  wire logic                                  i_clock,
  input  wire logic                                  i_reset_n,
  // APB slave
  input  wire logic                                  i_psel,
  input  wire logic                                  i_penable,
  input  wire logic                                  i_pwrite,
  input  wire logic [watchdog_pkg::ADDR_WIDTH-1:0]   i_paddr,
  input  wire logic [31:0]                           i_pwdata,
  output logic      [31:0]                           o_prdata,
  output logic                                       o_pready,
  output logic                                       o_pslverr,
  // Chip state
  input  wire logic                                  i_count_tick,
  input  wire logic                                  i_special_mode,
  input  wire logic                                  i_debug_active,
  input  wire logic                                  i_wait_mode,
  input  wire logic                                  i_stop_mode,
  input  wire logic [3:0]                            i_flash_option_byte,
  // Results
  output logic                                       o_reset_request,
  output logic                                       o_tick_timer_halt
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic [15:0] count;
    logic [2:0]  rate;
    logic        window;
    logic        stop_dbg;
    logic        halt_wait;
    logic        run_stop;
    logic        once_used;
    logic        armed;
    logic        loaded;
    logic        reset_req;
    logic        tick_halt;
  } state_t;

  state_t state;
  state_t next_state;

  // ----------------------------------------------------------------
  // Period lookup
  // ----------------------------------------------------------------
  function automatic logic [4:0] rate_exp(input logic [2:0] code);
    logic [4:0] e;
    e = watchdog_pkg::EXP_R7;
    unique case (code)
      3'h1: e = watchdog_pkg::EXP_R1;
      3'h2: e = watchdog_pkg::EXP_R2;
      3'h3: e = watchdog_pkg::EXP_R3;
      3'h4: e = watchdog_pkg::EXP_R4;
      3'h5: e = watchdog_pkg::EXP_R5;
      3'h6: e = watchdog_pkg::EXP_R6;
      3'h7: e = watchdog_pkg::EXP_R7;
      3'h0: e = watchdog_pkg::EXP_R7;
    endcase
    return e;
  endfunction

  // ----------------------------------------------------------------
  // Decode and derived levels
  // ----------------------------------------------------------------
  logic        setup;
  logic        access;
  logic        hit_ctrl;
  logic        hit_serv;
  logic        enabled;
  logic        override;
  logic [2:0]  eff_rate;
  logic        eff_window;
  logic [16:0] period;
  logic [15:0] last_count;
  logic [15:0] window_start;
  logic        window_open;
  logic        dbg_halt;
  logic        stop_freeze;
  logic        wait_hold;

  assign setup    = i_psel & ~i_penable;
  assign access   = i_psel & i_penable & state.pready;
  assign hit_ctrl = (i_paddr == {watchdog_pkg::CONTROL_INDEX, 2'b00});
  assign hit_serv = (i_paddr == {watchdog_pkg::SERVICE_INDEX, 2'b00});
  assign enabled  = (state.rate != watchdog_pkg::RATE_OFF);
  // Debugging a special-mode part must not trip the window
  assign override = enabled & i_debug_active & ~state.stop_dbg &
                    i_special_mode;
  assign eff_rate   = override ? watchdog_pkg::RATE_LONGEST
                               : state.rate;
  assign eff_window = state.window & ~override;
  assign period     = 17'h00001 << rate_exp(eff_rate);
  assign last_count = 16'(period - 17'h00001);
  assign window_start = last_count - (last_count >> 2);
  assign window_open  = (state.count >= window_start);
  assign dbg_halt     = state.stop_dbg & i_debug_active;
  assign stop_freeze  = i_stop_mode & ~state.run_stop;
  assign wait_hold    = i_wait_mode & state.halt_wait;

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    logic       wr_ctrl;
    logic       wr_serv;
    logic       may_write;
    logic       restart;
    logic [7:0] d;
    next_state = state;
    wr_ctrl    = access & i_pwrite & hit_ctrl;
    wr_serv    = access & i_pwrite & hit_serv;
    d          = i_pwdata[7:0];
    restart    = 1'b0;
    may_write  = i_special_mode | ~state.once_used;

    // Zero wait states: answer is ready in the first access cycle
    next_state.pready  = setup;
    next_state.pslverr = setup & ~(hit_ctrl | hit_serv);
    next_state.prdata  = 32'h00000000;
    if (setup && hit_ctrl) begin
      // Mask bit is write-only and reads as zero
      next_state.prdata[7:0] = {state.window, state.stop_dbg, 1'b0,
                                state.halt_wait, state.run_stop,
                                state.rate};
    end
    // Service register reads zero by leaving prdata cleared

    if (!state.loaded) begin
      // Options sampled once, on the first edge after release
      next_state.loaded = 1'b1;
      next_state.rate   = ~i_flash_option_byte[2:0];
      next_state.window =
        ~i_flash_option_byte[watchdog_pkg::OPT_WINDOW];
      restart = 1'b1;
    end else if (wr_ctrl) begin
      if (!d[watchdog_pkg::MASK_BIT] && may_write) begin
        if (!i_special_mode) begin
          next_state.once_used = 1'b1;
        end
        if (d[watchdog_pkg::RATE_MSB:0] != watchdog_pkg::RATE_OFF) begin
          next_state.rate = d[watchdog_pkg::RATE_MSB:0];
          restart = 1'b1;
        end
        if (d[watchdog_pkg::WINDOW_BIT]) begin
          next_state.window = 1'b1;
        end
        next_state.halt_wait = d[watchdog_pkg::WAIT_BIT];
        next_state.run_stop  = d[watchdog_pkg::STOP_BIT];
      end
      if (i_special_mode) begin
        next_state.stop_dbg = d[watchdog_pkg::DEBUG_BIT];
      end else begin
        next_state.stop_dbg = state.stop_dbg |
                              d[watchdog_pkg::DEBUG_BIT];
      end
      if (!state.stop_dbg && d[watchdog_pkg::DEBUG_BIT] &&
          (i_special_mode || !state.stop_dbg)) begin
        restart = 1'b1;
      end
    end

    if (wr_serv && enabled) begin
      if ((d != watchdog_pkg::KEY_FIRST) &&
          (d != watchdog_pkg::KEY_SECOND)) begin
        next_state.reset_req = 1'b1;
      end else if (eff_window && !window_open) begin
        next_state.reset_req = 1'b1;
      end else if (d == watchdog_pkg::KEY_FIRST) begin
        next_state.armed = 1'b1;
      end else if (state.armed) begin
        restart = 1'b1;
      end
      // A lone second key only restarts once armed
    end

    // Counter advances on reference ticks only; the tick is taken as
    // already synchronous to this clock
    if (restart || wait_hold) begin
      next_state.count = 16'h0000;
      next_state.armed = 1'b0;
    end else if (enabled && i_count_tick && !dbg_halt &&
                 !stop_freeze) begin
      if (state.count >= last_count) begin
        next_state.reset_req = 1'b1;
        next_state.count     = 16'h0000;
        next_state.armed     = 1'b0;
      end else begin
        next_state.count = state.count + 16'h0001;
      end
    end

    next_state.tick_halt = dbg_halt;
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge i_clock) begin
    if (!i_reset_n) begin
      state           <= '0;
      state.rate      <= watchdog_pkg::RATE_OFF;
      state.stop_dbg  <= watchdog_pkg::FIELD_RESET;
      state.halt_wait <= watchdog_pkg::FIELD_RESET;
      state.run_stop  <= watchdog_pkg::FIELD_RESET;
    end else begin
      state <= next_state;
    end
  end

  assign o_prdata          = state.prdata;
  assign o_pready          = state.pready;
  assign o_pslverr         = state.pslverr;
  assign o_reset_request   = state.reset_req;
  assign o_tick_timer_halt = state.tick_halt;

endmodule

//--- watchdog_properties.sv
`timescale 1ns/10ps
module watchdog_properties (
  // Bus side
  input wire logic                                 i_clock,
  input wire logic                                 i_reset_n,
  input wire logic                                 i_psel,
  input wire logic                                 i_penable,
  input wire logic                                 i_pwrite,
  input wire logic [watchdog_pkg::ADDR_WIDTH-1:0]  i_paddr,
  input wire logic [31:0]                          o_prdata,
  input wire logic                                 o_pready,
  input wire logic                                 o_pslverr,
  // Chip side
  input wire logic                                 i_debug_active,
  input wire logic                                 o_reset_request,
  input wire logic                                 o_tick_timer_halt
);
  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  default clocking @(posedge i_clock); endclocking
  default disable iff (!i_reset_n);
  localparam logic [9:0] CTRL_ADDR = {watchdog_pkg::CONTROL_INDEX, 2'b00};
  localparam logic [9:0] SERV_ADDR = {watchdog_pkg::SERVICE_INDEX, 2'b00};
  logic rd;
  assign rd = o_pready && !i_pwrite;
  // Only a service write can raise a reset before the shortest period
  logic [6:0] since;
  logic       serv_seen;
  always_ff @(posedge i_clock) begin
    if (!i_reset_n) begin
      since     <= 7'h00;
      serv_seen <= 1'b0;
    end else begin
      if (since != 7'h7f) begin
        since <= since + 7'h01;
      end
      if (o_pready && i_psel && i_penable && i_pwrite &&
          i_paddr == SERV_ADDR) begin
        serv_seen <= 1'b1;
      end
    end
  end
  chk_ready_after_setup: assert property (
    i_psel && !i_penable |=> o_pready) else $error("no ready after setup");
  chk_ready_one_cycle: assert property (
    o_pready |=> !o_pready) else $error("ready held too long");
  chk_mapped_no_error: assert property (
    o_pready && (i_paddr == CTRL_ADDR || i_paddr == SERV_ADDR) |-> !o_pslverr)
    else $error("error on mapped address");
  chk_unmapped_error: assert property (
    o_pready && i_paddr != CTRL_ADDR && i_paddr != SERV_ADDR |-> o_pslverr)
    else $error("no error on unmapped address");
  chk_mask_reads_zero: assert property (
    rd && i_paddr == 10'h0f8 |-> o_prdata[31:8] == 24'h0 && !o_prdata[5])
    else $error("mask or upper bits read nonzero");
  chk_service_reads_zero: assert property (
    rd && i_paddr == 10'h0fc |-> o_prdata == 32'h0)
    else $error("service register read nonzero");
  chk_reset_sticky: assert property (
    o_reset_request |=> o_reset_request) else $error("reset request dropped");
  chk_no_early_reset: assert property (
    !serv_seen && since < 7'h40 |-> !o_reset_request)
    else $error("reset request before shortest period");
  chk_halt_tracks_debug: assert property (
    $fell(i_debug_active) |=> !o_tick_timer_halt)
    else $error("tick halt outlived debug");
  cover property (o_reset_request);
  cover property (o_pslverr);
  cover property (o_tick_timer_halt);
endmodule

bind windowed_watchdog_control watchdog_properties chk (
  .i_clock(i_clock), .i_reset_n(i_reset_n), .i_psel(i_psel),
  .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr),
  .o_prdata(o_prdata), .o_pready(o_pready), .o_pslverr(o_pslverr),
  .i_debug_active(i_debug_active), .o_reset_request(o_reset_request),
  .o_tick_timer_halt(o_tick_timer_halt));

//--- windowed_watchdog_control_tb.sv
`timescale 1ns/10ps
module windowed_watchdog_control_tb;
  localparam logic [9:0] CTRL = {watchdog_pkg::CONTROL_INDEX, 2'b00};
  localparam logic [9:0] SERV = {watchdog_pkg::SERVICE_INDEX, 2'b00};
  logic        clock, reset_n, psel, penable, pwrite, tick, e;
  logic        special, debug, waitm, stopm, pready, pslverr;
  logic        reset_request, tick_halt;
  logic [9:0]  paddr;
  logic [31:0] pwdata, prdata, r;
  logic [3:0]  opt;
  int          n_errors, tests_run;
  int          exps [6] = '{6, 8, 10, 12, 14, 15};

  windowed_watchdog_control uut (
    .i_clock(clock), .i_reset_n(reset_n), .i_psel(psel),
    .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr),
    .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready),
    .o_pslverr(pslverr), .i_count_tick(tick), .i_special_mode(special),
    .i_debug_active(debug), .i_wait_mode(waitm), .i_stop_mode(stopm),
    .i_flash_option_byte(opt), .o_reset_request(reset_request),
    .o_tick_timer_halt(tick_halt));

  always #2.5 clock = ~clock;

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic close_out();
    if (n_errors == 0 && tests_run > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic do_reset();
    reset_n <= 1'b0;
    repeat (20) @(posedge clock);
    reset_n <= 1'b1;
    @(posedge clock);
  endtask

  // Idle edge after release so back-to-back calls never double-drive
  task automatic xfer(input logic w, input logic [9:0] a,
                      input logic [7:0] d);
    int k;
    k = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge clock);
    penable <= 1'b1;
    do begin
      @(posedge clock);
      k++;
    end while (pready !== 1'b1 && k < 20);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1) begin
      n_errors++;
      close_out();
    end else begin
      @(posedge clock);
    end
  endtask

  task automatic wr(input logic [9:0] a, input logic [7:0] d);
    xfer(1'b1, a, d);
  endtask

  task automatic rd(input logic [9:0] a, input logic [7:0] exp);
    xfer(1'b0, a, 8'h00);
    check(r, {24'h0, exp});
  endtask

  task automatic wait_rst(input int lo, input int hi);
    int k;
    k = 0;
    while (reset_request !== 1'b1 && k <= hi) begin
      @(posedge clock);
      k++;
    end
    check(32'(k >= lo && k <= hi), 32'h1);
    if (k > hi) begin
      close_out();
    end
  endtask

  task automatic quiet(input int n);
    repeat (n) @(posedge clock);
    check(32'(reset_request), 32'h0);
  endtask

  initial begin
    repeat (100000) @(posedge clock);
    n_errors++;
    close_out();
  end

  initial begin
    clock = 0; reset_n = 0; psel = 0; penable = 0; pwrite = 0;
    paddr = 0; pwdata = 0; tick = 1; special = 0; debug = 0;
    waitm = 0; stopm = 0; opt = 4'h6; n_errors = 0; tests_run = 0;
    do_reset();
    rd(CTRL, 8'h81);
    wr(SERV, 8'h55);
    wait_rst(0, 3);
    opt <= 4'hf;
    do_reset();
    rd(CTRL, 8'h00);
    wr(SERV, 8'h12);
    rd(SERV, 8'h00);
    quiet(100);
    xfer(1'b0, 10'h000, 8'h00);
    check(32'(e), 32'h1);
    wr(CTRL, 8'h63);
    rd(CTRL, 8'h40);
    wr(CTRL, 8'h01);
    wr(CTRL, 8'h07);
    wr(CTRL, 8'h00);
    rd(CTRL, 8'h41);
    repeat (30) @(posedge clock);
    wr(SERV, 8'h55);
    wr(SERV, 8'haa);
    wait_rst(58, 70);
    do_reset();
    wr(CTRL, 8'h01);
    wr(SERV, 8'h33);
    wait_rst(0, 3);
    do_reset();
    wr(CTRL, 8'h01);
    repeat (40) @(posedge clock);
    wr(CTRL, 8'h60);
    wait_rst(58, 70);
    do_reset();
    wr(CTRL, 8'h00);
    wr(CTRL, 8'h81);
    rd(CTRL, 8'h00);
    special <= 1'b1;
    for (int i = 0; i < 6; i++) begin
      do_reset();
      wr(CTRL, 8'(i + 1));
      wait_rst((1 << exps[i]) - 2, (1 << exps[i]) + 3);
    end
    do_reset();
    wr(CTRL, 8'h81);
    repeat (48) @(posedge clock);
    wr(SERV, 8'h55);
    wr(SERV, 8'h55);
    wr(SERV, 8'haa);
    wait_rst(58, 70);
    do_reset();
    wr(CTRL, 8'h81);
    repeat (50) @(posedge clock);
    wr(SERV, 8'haa);
    wait_rst(4, 14);
    do_reset();
    wr(CTRL, 8'h41);
    debug <= 1'b1;
    quiet(200);
    check(32'(tick_halt), 32'h1);
    wr(CTRL, 8'h01);
    quiet(200);
    debug <= 1'b0;
    do_reset();
    wr(CTRL, 8'h11);
    waitm <= 1'b1;
    quiet(200);
    waitm <= 1'b0;
    wait_rst(58, 70);
    do_reset();
    wr(CTRL, 8'h01);
    repeat (30) @(posedge clock);
    stopm <= 1'b1;
    quiet(200);
    stopm <= 1'b0;
    wait_rst(25, 40);
    do_reset();
    wr(CTRL, 8'h09);
    stopm <= 1'b1;
    wait_rst(55, 70);
    close_out();
  end
endmodule
